//--- hdl/dcso_pkg.sv
// Package: constants, states and carriers of the drive control and status objects
package dcso_pkg;
    // ============================================================
    // Object indexes and sub-indexes
    localparam logic [15:0] IDX_OUT_SYNC = 16'h1C32;
    localparam logic [15:0] IDX_IN_SYNC = 16'h1C33;
    localparam logic [15:0] IDX_ERROR_CODE = 16'h603F;
    localparam logic [15:0] IDX_CMD_WORD = 16'h6040;
    localparam logic [15:0] IDX_STATE_WORD = 16'h6041;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_SYNC_TYPE = 8'h01;
    localparam logic [7:0] SUB_CYCLE_TIME = 8'h02;
    localparam logic [7:0] SUB_SHIFT_TIME = 8'h03;
    localparam logic [7:0] SUB_TYPES_SUPP = 8'h04;
    localparam logic [7:0] SUB_MIN_CYCLE = 8'h05;
    localparam logic [7:0] SUB_CALC_COPY = 8'h06;
    localparam logic [7:0] SUB_DELAY_TIME = 8'h09;
    localparam logic [7:0] SUB_SYNC_ERROR = 8'h20;
    localparam logic [31:0] SYNC_ENTRY_COUNT = 32'h0000_0020;

    // ============================================================
    // Synchronization encodings and fixed values
    localparam logic [15:0] IN_SYNC_FREE_RUN = 16'h0000;
    localparam logic [15:0] IN_SYNC_DC = 16'h0002;
    localparam logic [15:0] IN_SYNC_OUT_EVENT = 16'h0022;
    localparam logic [15:0] OUT_SYNC_FREE_RUN = 16'h0000;
    localparam logic [15:0] OUT_SYNC_EVENT = 16'h0001;
    localparam logic [15:0] OUT_SYNC_DC = 16'h0002;
    localparam logic [15:0] SYNC_TYPE_RESET = 16'h0002;
    localparam logic [31:0] TYPES_SUPPORTED = 32'h0000_0007;
    localparam logic [31:0] MIN_CYCLE_NS = 32'h0007_A120;
    localparam logic [31:0] OUT_CALC_COPY_NS = 32'h0001_E848;
    localparam logic [31:0] IN_CALC_COPY_NS = 32'h0003_0D40;
    localparam logic [31:0] UNSUPPORTED_TIME = 32'h0000_0000;

    // ============================================================
    // Word fields and reset values
    localparam logic [15:0] CMD_WORD_RESET = 16'h0000;
    localparam logic [15:0] ERROR_NONE = 16'h0000;
    localparam logic [7:0] ERROR_HIGH = 8'hFF;
    localparam int CMD_SWITCH_ON = 0;
    localparam int CMD_ENABLE_VOLTAGE = 1;
    localparam int CMD_QUICK_STOP = 2;
    localparam int CMD_ENABLE_OP = 3;
    localparam int CMD_FAULT_RESET = 7;
    localparam int ST_WARNING = 7;
    localparam int ST_INIT_DONE = 9;
    localparam int ST_LIMIT = 11;

    // ============================================================
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam logic [31:0] CLK_NS_STEP = 32'(CLK_PERIOD_NS);

    // ============================================================
    // Types
    typedef enum {
        DCSO_NOT_READY,
        DCSO_SWITCH_ON_DISABLED,
        DCSO_READY,
        DCSO_SWITCHED_ON,
        DCSO_OP_ENABLED,
        DCSO_QUICK_STOP,
        DCSO_FAULT
    } dcso_state_t;

    typedef struct packed {
        logic write;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } dcso_od_req_t;

    typedef struct packed {
        logic alarm_active;
        logic [7:0] alarm_code;
        logic warning;
        logic init_done;
        logic limit_active;
    } dcso_drive_in_t;
endpackage

//--- hdl/dcso_objects.sv
// Module: drive control word, status word, error code and sync manager objects
`timescale 1ns/1ps

module dcso_objects
    import dcso_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic sync0_pin,
    input wire logic rx_pdo_valid,
    input wire logic [15:0] rx_cmd_word,
    output logic tx_pdo_valid,
    output logic [15:0] tx_state_word,
    output logic [15:0] tx_error_code,
    input wire logic od_req,
    input wire dcso_od_req_t od_cmd,
    output logic od_ack,
    output logic od_err,
    output logic [31:0] od_rdata,
    input wire dcso_drive_in_t drive_in,
    output logic alarm_clear,
    output logic [15:0] cmd_word
);

    // ============================================================
    // Declarations
    logic sync0_meta_reg;
    logic sync0_sync_reg;
    logic sync0_prev_reg;
    logic sync0_rise;
    logic [31:0] period_cnt_reg;
    logic [31:0] cycle_ns_reg;
    logic [15:0] in_sync_type_reg;
    logic [15:0] out_sync_type_reg;
    logic sync_error_reg;
    logic sync0_seen_reg;
    logic [15:0] cmd_word_reg;
    logic [15:0] cmd_word_next;
    logic cmd_update;
    logic fault_reset_rise;
    dcso_state_t state_reg;
    dcso_state_t state_next;
    logic [15:0] state_word;
    logic [15:0] error_code;
    logic od_wr_in_type;
    logic od_wr_out_type;
    logic od_wr_cmd;
    logic in_type_ok;
    logic out_type_ok;
    logic [31:0] rd_value;
    logic rd_hit;
    logic wr_ok;

    // ============================================================
    // SYNC0 pin capture and period measurement

    // Two-flop synchroniser, then edge detect on the second stage
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync0_meta_reg <= 1'b0;
            sync0_sync_reg <= 1'b0;
            sync0_prev_reg <= 1'b0;
        end
        else
        begin
            sync0_meta_reg <= sync0_pin;
            sync0_sync_reg <= sync0_meta_reg;
            sync0_prev_reg <= sync0_sync_reg;
        end
    end

    assign sync0_rise = sync0_sync_reg && !sync0_prev_reg;

    // Nanosecond counter between SYNC0 edges; idles at zero until the first edge
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            period_cnt_reg <= 32'h0000_0000;
            cycle_ns_reg <= 32'h0000_0000;
        end
        else if (sync0_rise)
        begin
            period_cnt_reg <= CLK_NS_STEP;
            cycle_ns_reg <= period_cnt_reg;
        end
        else if ((period_cnt_reg != 32'h0000_0000) && (period_cnt_reg != 32'hFFFF_FFFF))
        begin
            period_cnt_reg <= period_cnt_reg + CLK_NS_STEP;
        end
    end

    // ============================================================
    // Object access decode

    // Legal sync type encodings
    assign in_type_ok = (od_cmd.wdata[15:0] == IN_SYNC_FREE_RUN)
        || (od_cmd.wdata[15:0] == IN_SYNC_DC)
        || (od_cmd.wdata[15:0] == IN_SYNC_OUT_EVENT);
    assign out_type_ok = (od_cmd.wdata[15:0] == OUT_SYNC_FREE_RUN)
        || (od_cmd.wdata[15:0] == OUT_SYNC_EVENT)
        || (od_cmd.wdata[15:0] == OUT_SYNC_DC);

    assign od_wr_in_type = od_req && od_cmd.write && (od_cmd.index == IDX_IN_SYNC)
        && (od_cmd.sub == SUB_SYNC_TYPE) && in_type_ok;
    assign od_wr_out_type = od_req && od_cmd.write && (od_cmd.index == IDX_OUT_SYNC)
        && (od_cmd.sub == SUB_SYNC_TYPE) && out_type_ok;
    assign od_wr_cmd = od_req && od_cmd.write && (od_cmd.index == IDX_CMD_WORD)
        && (od_cmd.sub == SUB_COUNT);
    assign wr_ok = od_wr_in_type || od_wr_out_type || od_wr_cmd;

    // Read multiplexer over both sync objects and the profile words
    always_comb
    begin
        rd_value = 32'h0000_0000;
        rd_hit = 1'b1;
        if ((od_cmd.index == IDX_IN_SYNC) || (od_cmd.index == IDX_OUT_SYNC))
        begin
            case (od_cmd.sub)
                SUB_COUNT: rd_value = SYNC_ENTRY_COUNT;
                SUB_SYNC_TYPE: rd_value = {16'h0000, (od_cmd.index == IDX_IN_SYNC)
                    ? in_sync_type_reg : out_sync_type_reg};
                SUB_CYCLE_TIME: rd_value = cycle_ns_reg;
                SUB_SHIFT_TIME: rd_value = UNSUPPORTED_TIME;
                SUB_TYPES_SUPP: rd_value = TYPES_SUPPORTED;
                SUB_MIN_CYCLE: rd_value = MIN_CYCLE_NS;
                SUB_CALC_COPY: rd_value = (od_cmd.index == IDX_IN_SYNC)
                    ? IN_CALC_COPY_NS : OUT_CALC_COPY_NS;
                SUB_DELAY_TIME: rd_value = UNSUPPORTED_TIME;
                SUB_SYNC_ERROR: rd_value = {31'h0000_0000, sync_error_reg};
                default: rd_hit = 1'b0;
            endcase
        end
        else if (od_cmd.sub != SUB_COUNT)
        begin
            rd_hit = 1'b0;
        end
        else
        begin
            case (od_cmd.index)
                IDX_ERROR_CODE: rd_value = {16'h0000, error_code};
                IDX_CMD_WORD: rd_value = {16'h0000, cmd_word_reg};
                IDX_STATE_WORD: rd_value = {16'h0000, state_word};
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // Registered answer one cycle after the request; bad writes flag an error
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            od_ack <= 1'b0;
            od_err <= 1'b0;
            od_rdata <= 32'h0000_0000;
        end
        else
        begin
            od_ack <= od_req;
            od_err <= od_req && (od_cmd.write ? !wr_ok : !rd_hit);
            od_rdata <= (od_req && !od_cmd.write && rd_hit) ? rd_value : 32'h0000_0000;
        end
    end

    // ============================================================
    // Sync type settings and sync error

    // Sync type registers take only legal encodings
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            in_sync_type_reg <= SYNC_TYPE_RESET;
            out_sync_type_reg <= SYNC_TYPE_RESET;
        end
        else
        begin
            if (od_wr_in_type)
            begin
                in_sync_type_reg <= od_cmd.wdata[15:0];
            end
            if (od_wr_out_type)
            begin
                out_sync_type_reg <= od_cmd.wdata[15:0];
            end
        end
    end

    // In SYNC0 mode two updates with no SYNC0 between them is a sync error
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync0_seen_reg <= 1'b1;
            sync_error_reg <= 1'b0;
        end
        else
        begin
            if (sync0_rise)
            begin
                sync0_seen_reg <= 1'b1;
            end
            else if (rx_pdo_valid)
            begin
                sync0_seen_reg <= 1'b0;
            end
            if (rx_pdo_valid && !sync0_seen_reg && !sync0_rise
                && (in_sync_type_reg == IN_SYNC_DC))
            begin
                sync_error_reg <= 1'b1;
            end
            else if (od_wr_in_type)
            begin
                sync_error_reg <= 1'b0;
            end
        end
    end

    // ============================================================
    // Command word and fault reset edge

    assign cmd_update = rx_pdo_valid || od_wr_cmd;

    // Process data has priority over an object write in the same cycle
    always_comb
    begin
        cmd_word_next = cmd_word_reg;
        if (rx_pdo_valid)
        begin
            cmd_word_next = rx_cmd_word;
        end
        else if (od_wr_cmd)
        begin
            cmd_word_next = od_cmd.wdata[15:0];
        end
    end

    // Edge against the value of the previous update only
    assign fault_reset_rise = cmd_update && cmd_word_next[CMD_FAULT_RESET]
        && !cmd_word_reg[CMD_FAULT_RESET];

    // Command word register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_word_reg <= CMD_WORD_RESET;
            alarm_clear <= 1'b0;
        end
        else
        begin
            cmd_word_reg <= cmd_word_next;
            alarm_clear <= fault_reset_rise && (state_reg == DCSO_FAULT);
        end
    end

    assign cmd_word = cmd_word_reg;

    // ============================================================
    // Drive state machine

    // Transitions chosen by command bits 0 to 3, by init_done, by an alarm and by the bit 7 fault reset edge
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            DCSO_NOT_READY:
                if (drive_in.init_done)
                begin
                    state_next = DCSO_SWITCH_ON_DISABLED;
                end
            DCSO_SWITCH_ON_DISABLED:
                if (cmd_word_reg[CMD_ENABLE_VOLTAGE] && cmd_word_reg[CMD_QUICK_STOP]
                    && !cmd_word_reg[CMD_SWITCH_ON])
                begin
                    state_next = DCSO_READY;
                end
            DCSO_READY:
                if (!cmd_word_reg[CMD_ENABLE_VOLTAGE] || !cmd_word_reg[CMD_QUICK_STOP])
                begin
                    state_next = DCSO_SWITCH_ON_DISABLED;
                end
                else if (cmd_word_reg[CMD_SWITCH_ON])
                begin
                    state_next = DCSO_SWITCHED_ON;
                end
            DCSO_SWITCHED_ON:
                if (!cmd_word_reg[CMD_ENABLE_VOLTAGE] || !cmd_word_reg[CMD_QUICK_STOP])
                begin
                    state_next = DCSO_SWITCH_ON_DISABLED;
                end
                else if (!cmd_word_reg[CMD_SWITCH_ON])
                begin
                    state_next = DCSO_READY;
                end
                else if (cmd_word_reg[CMD_ENABLE_OP])
                begin
                    state_next = DCSO_OP_ENABLED;
                end
            DCSO_OP_ENABLED:
                if (!cmd_word_reg[CMD_ENABLE_VOLTAGE])
                begin
                    state_next = DCSO_SWITCH_ON_DISABLED;
                end
                else if (!cmd_word_reg[CMD_QUICK_STOP])
                begin
                    state_next = DCSO_QUICK_STOP;
                end
                else if (!cmd_word_reg[CMD_SWITCH_ON])
                begin
                    state_next = DCSO_READY;
                end
                else if (!cmd_word_reg[CMD_ENABLE_OP])
                begin
                    state_next = DCSO_SWITCHED_ON;
                end
            DCSO_QUICK_STOP:
                if (!cmd_word_reg[CMD_ENABLE_VOLTAGE])
                begin
                    state_next = DCSO_SWITCH_ON_DISABLED;
                end
            DCSO_FAULT:
                if (fault_reset_rise)
                begin
                    state_next = DCSO_SWITCH_ON_DISABLED;
                end
            default:
                state_next = DCSO_NOT_READY;
        endcase
        // An alarm overrides any command, except the reset edge leaving fault
        if (drive_in.alarm_active && !(state_reg == DCSO_FAULT && fault_reset_rise))
        begin
            state_next = DCSO_FAULT;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= DCSO_NOT_READY;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ============================================================
    // Status word and error code

    // State bits 0 to 6 plus warning, init and limit indications
    always_comb
    begin
        state_word = 16'h0000;
        case (state_reg)
            DCSO_SWITCH_ON_DISABLED: state_word[6:0] = 7'h40;
            DCSO_READY: state_word[6:0] = 7'h21;
            DCSO_SWITCHED_ON: state_word[6:0] = 7'h23;
            DCSO_OP_ENABLED: state_word[6:0] = 7'h27;
            DCSO_QUICK_STOP: state_word[6:0] = 7'h07;
            DCSO_FAULT: state_word[6:0] = 7'h08;
            default: state_word[6:0] = 7'h00;
        endcase
        state_word[4] = cmd_word_reg[CMD_ENABLE_VOLTAGE] && (state_reg != DCSO_NOT_READY)
            && (state_reg != DCSO_SWITCH_ON_DISABLED);
        state_word[ST_WARNING] = drive_in.warning;
        state_word[ST_INIT_DONE] = drive_in.init_done;
        state_word[ST_LIMIT] = drive_in.limit_active;
    end

    // Alarm code in the low byte under a fixed high byte
    assign error_code = drive_in.alarm_active
        ? {ERROR_HIGH, drive_in.alarm_code}
        : ERROR_NONE;

    // Transmit words captured on every process data cycle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_pdo_valid <= 1'b0;
            tx_state_word <= 16'h0000;
            tx_error_code <= ERROR_NONE;
        end
        else
        begin
            tx_pdo_valid <= rx_pdo_valid;
            if (rx_pdo_valid)
            begin
                tx_state_word <= state_word;
                tx_error_code <= error_code;
            end
        end
    end

endmodule

//--- verification/dcso_master_model.sv
// Partner model: fieldbus master issuing process data frames and SYNC0 pulses
`timescale 1ns/1ps
module dcso_master_model
#(
    parameter int SYNC_PERIOD = 40
)
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic send,
    input wire logic [15:0] cmd,
    input wire logic sync_en,
    output logic rx_pdo_valid,
    output logic [15:0] rx_cmd_word,
    output logic sync0_pin
);
    logic [15:0] sync_cnt_reg;

    // ============================================================
    // One frame per send; the word is garbage outside frames
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_pdo_valid <= 1'b0;
            rx_cmd_word <= 16'h0000;
        end
        else
        begin
            rx_pdo_valid <= send;
            rx_cmd_word <= send ? cmd : ~rx_cmd_word;
        end
    end

    // ============================================================
    // SYNC0 pulse of two cycles every SYNC_PERIOD cycles while enabled
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_cnt_reg <= 16'h0000;
            sync0_pin <= 1'b0;
        end
        else
        begin
            sync_cnt_reg <= (sync_cnt_reg == 16'(SYNC_PERIOD - 1)) ? 16'h0000
                : sync_cnt_reg + 16'h0001;
            sync0_pin <= sync_en && (sync_cnt_reg < 16'h0002);
        end
    end
endmodule

//--- verification/dcso_objects_sva.sv
// Checker: concurrent assertions on the drive control and status object ports
`timescale 1ns/1ps
module dcso_objects_chk
    import dcso_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic rx_pdo_valid,
    input wire logic [15:0] rx_cmd_word,
    input wire logic tx_pdo_valid,
    input wire logic [15:0] tx_state_word,
    input wire logic [15:0] tx_error_code,
    input wire logic od_req,
    input wire dcso_od_req_t od_cmd,
    input wire logic od_ack,
    input wire logic od_err,
    input wire logic [31:0] od_rdata,
    input wire dcso_drive_in_t drive_in,
    input wire logic alarm_clear,
    input wire logic [15:0] cmd_word
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // ============================================================
    // Named steps
    sequence od_read(logic [7:0] s);
        od_req && !od_cmd.write && od_cmd.index == IDX_IN_SYNC && od_cmd.sub == s;
    endsequence
    sequence pdo_steady;
        rx_pdo_valid && drive_in == $past(drive_in) && drive_in == $past(drive_in, 2);
    endsequence

    // ============================================================
    // Assertions
    ack_timing_a: assert property (od_req |=> od_ack)
        else $error("object access not acknowledged");
    ack_idle_a: assert property (!od_req |=> !od_ack) else $error("acknowledge without request");
    pdo_answer_a: assert property (rx_pdo_valid |=> tx_pdo_valid
        && cmd_word == $past(rx_cmd_word)) else $error("process data cycle not answered");
    zero_entry_a: assert property (od_read(SUB_SHIFT_TIME) or od_read(SUB_DELAY_TIME)
        |=> !od_err && od_rdata == 32'h0000_0000) else $error("unsupported time not zero");
    types_supp_a: assert property (od_read(SUB_TYPES_SUPP) |=> od_rdata == 32'h0000_0007)
        else $error("supported types wrong");
    err_format_a: assert property (tx_pdo_valid |-> tx_error_code == 16'h0000
        || tx_error_code[15:8] == 8'hFF) else $error("error code high byte wrong");
    alarm_code_a: assert property (pdo_steady ##0 drive_in.alarm_active |=>
        tx_error_code == {8'hFF, $past(drive_in.alarm_code)}) else $error("alarm code wrong");
    status_flags_a: assert property (pdo_steady |=>
        tx_state_word[7] == $past(drive_in.warning)
        && tx_state_word[9] == $past(drive_in.init_done)
        && tx_state_word[11] == $past(drive_in.limit_active)) else $error("status flags wrong");
    state_code_a: assert property (tx_pdo_valid |-> (tx_state_word[6:0] & 7'h6F) inside
        {7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h07, 7'h08}) else $error("illegal state code");
    clear_edge_a: assert property (alarm_clear |-> cmd_word[7]
        && !$past(cmd_word[7])) else $error("alarm cleared without rising edge");
    clear_pulse_a: assert property (alarm_clear |=> !alarm_clear)
        else $error("clear pulse too long");
endmodule

bind dcso_objects dcso_objects_chk chk_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .rx_pdo_valid(rx_pdo_valid), .rx_cmd_word(rx_cmd_word), .tx_pdo_valid(tx_pdo_valid),
    .tx_state_word(tx_state_word), .tx_error_code(tx_error_code), .od_req(od_req),
    .od_cmd(od_cmd), .od_ack(od_ack), .od_err(od_err), .od_rdata(od_rdata),
    .drive_in(drive_in), .alarm_clear(alarm_clear), .cmd_word(cmd_word));

//--- verification/test_drive_control_status_objects.sv
// Testbench: self-checking bench for the drive control and status objects
`timescale 1ns/1ps
module test_drive_control_status_objects;
    import dcso_pkg::*;
    localparam int SYNC_P = 40;
    logic sys_clk, arst_n, m_send, m_sync_en, rx_pdo_valid, sync0_pin, tx_pdo_valid;
    logic od_req, od_ack, od_err, alarm_clear, err;
    logic [15:0] m_cmd, rx_cmd_word, tx_state_word, tx_error_code, cmd_word, st, ec, last;
    logic [31:0] od_rdata, seed, rd;
    dcso_od_req_t od_cmd;
    dcso_drive_in_t drive_in;
    int fails, tests_run, clears;

    dcso_objects dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .sync0_pin(sync0_pin),
        .rx_pdo_valid(rx_pdo_valid), .rx_cmd_word(rx_cmd_word), .tx_pdo_valid(tx_pdo_valid),
        .tx_state_word(tx_state_word), .tx_error_code(tx_error_code), .od_req(od_req),
        .od_cmd(od_cmd), .od_ack(od_ack), .od_err(od_err), .od_rdata(od_rdata),
        .drive_in(drive_in), .alarm_clear(alarm_clear), .cmd_word(cmd_word));
    dcso_master_model #(.SYNC_PERIOD(SYNC_P)) master_u (.sys_clk(sys_clk), .arst_n(arst_n),
        .send(m_send), .cmd(m_cmd), .sync_en(m_sync_en), .rx_pdo_valid(rx_pdo_valid),
        .rx_cmd_word(rx_cmd_word), .sync0_pin(sync0_pin));

    // ============================================================
    // Helpers
    function automatic logic [31:0] xs(logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic logic [15:0] exp_err(logic act, logic [7:0] code);
        return act ? {8'hFF, code} : 16'h0000;
    endfunction
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask
    task automatic od(logic w, logic [15:0] idx, logic [7:0] sb, logic [31:0] wd);
        od_cmd = {w, idx, sb, wd};
        od_req = 1'b1;
        @(posedge sys_clk);
        #1;
        od_req = 1'b0;
        chk("od_ack", 1, od_ack);
        err = od_err;
        rd = od_rdata;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic pdo(logic [15:0] c);
        m_cmd = c;
        m_send = 1'b1;
        @(posedge sys_clk);
        #1;
        m_send = 1'b0;
        for (int n = 0; n < 6 && tx_pdo_valid !== 1'b1; n++)
        begin
            @(posedge sys_clk);
            #1;
        end
        chk("tx_pdo_valid", 1, tx_pdo_valid);
        st = tx_state_word;
        ec = tx_error_code;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ============================================================
    // Clock, watchdog and fault reset pulse counter
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #(CLK_PERIOD_NS * 20000);
        fails++;
        tally_and_finish();
    end
    always @(posedge sys_clk)
        if (alarm_clear === 1'b1)
            clears++;

    // ============================================================
    // Main sequence
    initial
    begin
        static logic [15:0] t_idx[9] = '{16'h6040, 16'h1C33, 16'h1C33, 16'h1C33, 16'h1C33,
            16'h1C33, 16'h1C33, 16'h1C32, 16'h1C33};
        static logic [7:0] t_sub[9] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h06,
            8'h00};
        static logic [31:0] t_exp[9] = '{32'h0, 32'h2, 32'h0, 32'h7, 32'h0007_A120,
            32'h0003_0D40, 32'h0, 32'h0001_E848, 32'h0000_0020};
        static logic [15:0] s_code[8] = '{16'h00, 16'h22, 16'h01, 16'h02, 16'h01, 16'h22,
            16'h00, 16'h02};
        static logic [7:0] s_ok = 8'b1101_1011;
        static logic [15:0] sm_cmd[5] = '{16'h0000, 16'h0006, 16'h0007, 16'h000F, 16'h000B};
        static logic [6:0] sm_exp[5] = '{7'h40, 7'h21, 7'h23, 7'h27, 7'h07};
        static logic [15:0] bad_idx[3] = '{16'h6041, 16'h1234, 16'h1C33};
        arst_n = 1'b0;
        m_send = 1'b0;
        m_cmd = 16'h0000;
        m_sync_en = 1'b0;
        od_req = 1'b0;
        od_cmd = '0;
        drive_in = '0;
        drive_in.init_done = 1'b1;
        fails = 0;
        tests_run = 0;
        clears = 0;
        seed = 32'h92b8_78ee;
        repeat (16) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        @(posedge sys_clk);
        #1;
        for (int i = 0; i < 9; i++)
        begin
            od(1'b0, t_idx[i], t_sub[i], 32'h0);
            chk("object entry", t_exp[i], rd);
        end
        for (int i = 0; i < 8; i++)
        begin
            if (s_ok[7 - i])
                last = s_code[i];
            od(1'b1, (i < 4) ? IDX_IN_SYNC : IDX_OUT_SYNC, SUB_SYNC_TYPE, {16'h0, s_code[i]});
            chk("sync type refused", !s_ok[7 - i], err);
            od(1'b0, (i < 4) ? IDX_IN_SYNC : IDX_OUT_SYNC, SUB_SYNC_TYPE, 32'h0);
            chk("sync type", last, rd);
        end
        for (int i = 0; i < 3; i++)
        begin
            od(1'b1, bad_idx[i], (i == 2) ? SUB_MIN_CYCLE : 8'h00, 32'h1);
            chk("refused write", 1, err);
        end
        od(1'b0, IDX_IN_SYNC, SUB_CYCLE_TIME, 32'h0);
        chk("cycle time idle", 0, rd);
        m_sync_en = 1'b1;
        repeat (3 * SYNC_P) @(posedge sys_clk);
        #1;
        od(1'b0, IDX_IN_SYNC, SUB_CYCLE_TIME, 32'h0);
        chk("cycle time", SYNC_P * CLK_PERIOD_NS, rd);
        m_sync_en = 1'b0;
        od(1'b1, IDX_IN_SYNC, SUB_SYNC_TYPE, 32'h2);
        od(1'b0, IDX_IN_SYNC, SUB_SYNC_ERROR, 32'h0);
        chk("sync error clear", 0, rd[0]);
        pdo(16'h0000);
        pdo(16'h0000);
        od(1'b0, IDX_IN_SYNC, SUB_SYNC_ERROR, 32'h0);
        chk("sync error set", 1, rd[0]);
        for (int i = 0; i < 5; i++)
        begin
            pdo(sm_cmd[i]);
            pdo(sm_cmd[i]);
            chk("state code", sm_exp[i], st[6:0] & 7'h6F);
        end
        seed = xs(seed);
        drive_in.alarm_code = seed[7:0];
        drive_in.alarm_active = 1'b1;
        pdo(16'h000B);
        pdo(16'h000B);
        chk("fault state", 7'h08, st[6:0] & 7'h6F);
        chk("error code", exp_err(1'b1, seed[7:0]), ec);
        drive_in.alarm_active = 1'b0;
        pdo(16'h000B);
        chk("fault held", 7'h08, st[6:0] & 7'h6F);
        pdo(16'h0080);
        pdo(16'h0080);
        pdo(16'h0080);
        chk("clear pulses", 1, clears);
        chk("after clear", 7'h40, st[6:0] & 7'h6F);
        chk("no alarm code", exp_err(1'b0, 8'h00), ec);
        for (int i = 0; i < 6; i++)
        begin
            seed = xs(seed);
            drive_in.warning = seed[0];
            drive_in.init_done = seed[1];
            drive_in.limit_active = seed[2];
            pdo(16'h0000);
            pdo(16'h0000);
            chk("status flags", seed[2:0], {st[11], st[9], st[7]});
        end
        seed = xs(seed);
        od(1'b1, IDX_CMD_WORD, 8'h00, {16'h0, seed[15:0] & 16'hFF70});
        chk("command write", {err, cmd_word}, {1'b0, seed[15:0] & 16'hFF70});
        od(1'b0, IDX_CMD_WORD, 8'h00, 32'h0);
        chk("command read", {16'h0, seed[15:0] & 16'hFF70}, rd);
        tally_and_finish();
    end
endmodule
